// ### inc/gdps_pkg.sv
// shared constants for the gate-drive protection setup block
package gdps_pkg;
   localparam int unsigned CLK_FREQ_MHZ = 40;
   localparam int unsigned CLK_FREQ_KHZ = 40000;
   localparam int ADDR_W = 8;
   localparam logic [7:0] SETUP_OFFSET = 8'hAC;
   localparam logic [7:0] STATUS_OFFSET = 8'hB0;
   localparam logic [7:0] MASK_OFFSET = 8'hB4;
   localparam logic [7:0] AUX_OFFSET = 8'hB8;
   localparam logic [31:0] SETUP_RST = 32'h0000_0000;
   localparam logic [31:0] SETUP_WMASK = 32'h8C0D_3703;
   localparam int PARITY_BIT = 31;
   localparam int SLEW_LSB = 26;
   localparam int OV_SEL_BIT = 19;
   localparam int OV_EN_BIT = 18;
   localparam int OVERTEMP_WARNING_REPORT_ENABLE_BIT = 16;
   localparam int OC_FILT_LSB = 12;
   localparam int OC_LVL_BIT = 10;
   localparam int OC_MODE_LSB = 8;
   localparam int GAIN_LSB = 0;
   localparam logic [1:0] SLEW_125 = 2'h2;
   localparam logic [1:0] SLEW_200 = 2'h3;
   localparam logic [1:0] OC_MODE_LATCH = 2'h0;
   localparam logic [1:0] OC_MODE_RETRY = 2'h1;
   localparam int ST_W = 4;
   localparam int ST_OC = 0;
   localparam int ST_OV = 1;
   localparam int ST_OTW = 2;
   localparam int ST_CFG = 3;
   localparam logic [3:0] STATUS_RST = 4'h0;
   localparam logic [3:0] MASK_RST = 4'h0;
   localparam logic AUTO_GAIN_RST = 1'b0;
   localparam int AUX_AUTO_BIT = 0;
   localparam int AUX_OCF_BIT = 8;
   localparam int AUX_OVF_BIT = 9;
   localparam int AUX_GATE_BIT = 10;
   localparam int SYNC_W = 3;
   localparam int FILT_CNT_W = 7;
   localparam int unsigned FILT0_NS = 200;
   localparam int unsigned FILT1_NS = 600;
   localparam int unsigned FILT2_NS = 1200;
   localparam int unsigned FILT3_NS = 1600;
   localparam logic [6:0] FILT0_CYC = 7'((FILT0_NS * CLK_FREQ_MHZ + 999) / 1000);
   localparam logic [6:0] FILT1_CYC = 7'((FILT1_NS * CLK_FREQ_MHZ + 999) / 1000);
   localparam logic [6:0] FILT2_CYC = 7'((FILT2_NS * CLK_FREQ_MHZ + 999) / 1000);
   localparam logic [6:0] FILT3_CYC = 7'((FILT3_NS * CLK_FREQ_MHZ + 999) / 1000);
   localparam int unsigned RETRY_TIME_MS = 500;
   localparam int RETRY_CNT_W = 25;
   localparam logic [24:0] RETRY_CYCLES_DFLT = 25'(RETRY_TIME_MS * CLK_FREQ_KHZ);
endpackage

// ### logic/gdps_sync.sv
// two-stage synchroniser for the protection comparator pins
`timescale 1ns/1ps
module gdps_sync
   import gdps_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic [SYNC_W-1:0] din,
   output logic [SYNC_W-1:0] dout
);
   typedef struct packed {
      logic [SYNC_W-1:0] meta;
      logic [SYNC_W-1:0] stable;
   } gdps_sync_state_t;

   gdps_sync_state_t state_reg;
   gdps_sync_state_t state_next;

   // first stage feeds only the second stage
   always_comb
   begin
      state_next = state_reg;
      state_next.meta = din;
      state_next.stable = state_reg.meta;
      if (!resetn)
      begin
         state_next = '0;
      end
   end

   always_ff @(posedge clk)
   begin
      state_reg <= state_next;
   end

   assign dout = state_reg.stable;
endmodule // gdps_sync

// ### logic/gdps_deglitch.sv
// overcurrent deglitch filter with selectable time
`timescale 1ns/1ps
module gdps_deglitch
   import gdps_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic level,
   input wire logic [1:0] filt_sel,
   output logic filtered
);
   typedef struct packed {
      logic [FILT_CNT_W-1:0] cnt;
      logic out;
   } gdps_filt_state_t;

   gdps_filt_state_t state_reg;
   gdps_filt_state_t state_next;
   logic [FILT_CNT_W-1:0] limit;

   always_comb
   begin
      unique case (filt_sel)
         2'h0: limit = FILT0_CYC;
         2'h1: limit = FILT1_CYC;
         2'h2: limit = FILT2_CYC;
         2'h3: limit = FILT3_CYC;
      endcase
      state_next = state_reg;
      if (!resetn)
      begin
         state_next = '0;
      end
      else if (!level)
      begin
         state_next.cnt = '0;
         state_next.out = 1'b0;
      end
      else
      begin
         // compare with < so a shorter time chosen mid-count cannot wrap
         if (state_reg.cnt < limit)
         begin
            state_next.cnt = state_reg.cnt + 1'b1;
         end
         state_next.out = (state_next.cnt >= limit);
      end
   end

   always_ff @(posedge clk)
   begin
      state_reg <= state_next;
   end

   assign filtered = state_reg.out;

   chk_filter_drop: assert property (@(posedge clk) disable iff (!resetn)
      !level |=> !filtered)
      else $error("filter output stayed high after input dropped");

   chk_filter_count: assert property (@(posedge clk) disable iff (!resetn)
      $rose(filtered) |-> (state_reg.cnt == limit) && $past(level))
      else $error("filter output rose before the deglitch count");
endmodule // gdps_deglitch

// ### logic/gdps_top.sv
// gate-drive protection setup register with overcurrent, overvoltage and warning control
`timescale 1ns/1ps
module gdps_top
   import gdps_pkg::*;
#(
   parameter logic [RETRY_CNT_W-1:0] RETRY_CYCLES = RETRY_CYCLES_DFLT
)
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [31:0] rdata,
   input wire logic oc_detect_pin,
   input wire logic ov_detect_pin,
   input wire logic otw_detect_pin,
   input wire logic [1:0] auto_gain_code,
   output logic [1:0] slew_code,
   output logic slew_valid,
   output logic ov_threshold_sel,
   output logic ov_fault,
   output logic otw_report,
   output logic oc_trip_level,
   output logic oc_fault,
   output logic gate_enable,
   output logic [1:0] sense_gain,
   output logic irq
);
   typedef struct packed {
      logic [31:0] setup;
      logic [ST_W-1:0] status;
      logic [ST_W-1:0] mask;
      logic auto_gain;
      logic [31:0] rdata;
      logic oc_fault;
      logic [RETRY_CNT_W-1:0] retry_cnt;
      logic ov_act_d;
      logic otw_act_d;
      logic [1:0] gain;
   } gdps_top_state_t;

   gdps_top_state_t state_reg;
   gdps_top_state_t state_next;

   logic [SYNC_W-1:0] pins_sync;
   logic oc_filt;
   logic ov_act;
   logic otw_act;
   logic oc_event;
   logic cfg_event;
   logic [ST_W-1:0] clr_bits;
   logic [ST_W-1:0] events;
   logic [1:0] oc_mode;

   gdps_sync u_sync (
      .clk(clk),
      .resetn(resetn),
      .din({otw_detect_pin, ov_detect_pin, oc_detect_pin}),
      .dout(pins_sync)
   );

   gdps_deglitch u_oc_filt (
      .clk(clk),
      .resetn(resetn),
      .level(pins_sync[0]),
      .filt_sel(state_reg.setup[OC_FILT_LSB +: 2]),
      .filtered(oc_filt)
   );

   assign oc_mode = state_reg.setup[OC_MODE_LSB +: 2];
   assign ov_act = pins_sync[1] & state_reg.setup[OV_EN_BIT];
   assign otw_act = pins_sync[2] & state_reg.setup[OVERTEMP_WARNING_REPORT_ENABLE_BIT];
   // level, so a retry into a still-present overcurrent trips again
   assign oc_event = oc_filt & ~state_reg.oc_fault;
   // invalid slew or response code written; hardware still acts safely
   assign cfg_event = wr_en && (addr == SETUP_OFFSET)
      && (!wdata[SLEW_LSB + 1] || wdata[OC_MODE_LSB + 1]);
   assign clr_bits = (wr_en && (addr == STATUS_OFFSET)) ? wdata[ST_W-1:0] : '0;

   always_comb
   begin
      events = '0;
      events[ST_OC] = oc_event;
      events[ST_OV] = ov_act & ~state_reg.ov_act_d;
      events[ST_OTW] = otw_act & ~state_reg.otw_act_d;
      events[ST_CFG] = cfg_event;
      state_next = state_reg;
      state_next.ov_act_d = ov_act;
      state_next.otw_act_d = otw_act;
      if (wr_en)
      begin
         unique case (addr)
            SETUP_OFFSET: state_next.setup = wdata & SETUP_WMASK;
            MASK_OFFSET: state_next.mask = wdata[ST_W-1:0];
            AUX_OFFSET: state_next.auto_gain = wdata[AUX_AUTO_BIT];
            default: state_next.setup = state_reg.setup;
         endcase
      end
      // set wins over a write-one clear in the same cycle
      state_next.status = (state_reg.status & ~clr_bits) | events;
      if (oc_event)
      begin
         state_next.oc_fault = 1'b1;
         state_next.retry_cnt = '0;
      end
      else if (state_reg.oc_fault)
      begin
         if (oc_mode == OC_MODE_RETRY)
         begin
            if (state_reg.retry_cnt == RETRY_CYCLES - 1'b1)
            begin
               state_next.oc_fault = 1'b0;
               state_next.retry_cnt = '0;
            end
            else
            begin
               state_next.retry_cnt = state_reg.retry_cnt + 1'b1;
            end
         end
         // invalid codes fall back to latching, the safer of the two
         else if (clr_bits[ST_OC] && !oc_filt)
         begin
            state_next.oc_fault = 1'b0;
         end
      end
      // static field ignored while automatic gain selection runs
      state_next.gain = state_reg.auto_gain ? auto_gain_code
         : state_reg.setup[GAIN_LSB +: 2];
      state_next.rdata = '0;
      if (rd_en)
      begin
         unique case (addr)
            SETUP_OFFSET: state_next.rdata = state_reg.setup;
            STATUS_OFFSET: state_next.rdata[ST_W-1:0] = state_reg.status;
            MASK_OFFSET: state_next.rdata[ST_W-1:0] = state_reg.mask;
            AUX_OFFSET:
            begin
               state_next.rdata[AUX_AUTO_BIT] = state_reg.auto_gain;
               state_next.rdata[AUX_OCF_BIT] = state_reg.oc_fault;
               state_next.rdata[AUX_OVF_BIT] = ov_act;
               state_next.rdata[AUX_GATE_BIT] = gate_enable;
            end
            default: state_next.rdata = '0;
         endcase
      end
      if (!resetn)
      begin
         state_next = '0;
         state_next.setup = SETUP_RST;
         state_next.status = STATUS_RST;
         state_next.mask = MASK_RST;
         state_next.auto_gain = AUTO_GAIN_RST;
      end
   end

   always_ff @(posedge clk)
   begin
      state_reg <= state_next;
   end

   assign rdata = state_reg.rdata;
   assign slew_code = state_reg.setup[SLEW_LSB +: 2];
   assign slew_valid = (slew_code == SLEW_125) || (slew_code == SLEW_200);
   assign ov_threshold_sel = state_reg.setup[OV_SEL_BIT];
   assign ov_fault = ov_act;
   assign otw_report = otw_act;
   assign oc_trip_level = state_reg.setup[OC_LVL_BIT];
   assign oc_fault = state_reg.oc_fault;
   assign gate_enable = ~state_reg.oc_fault & ~ov_act;
   assign sense_gain = state_reg.gain;
   assign irq = |(state_reg.status & state_reg.mask);

   chk_reset_clears: assert property (@(posedge clk)
      !resetn |=> (state_reg.setup == SETUP_RST) && !oc_fault && !irq)
      else $error("setup word not cleared by reset");

   chk_slew_decode: assert property (@(posedge clk) disable iff (!resetn)
      slew_valid == state_reg.setup[SLEW_LSB + 1])
      else $error("slew valid disagrees with stored code");

   chk_ov_enable: assert property (@(posedge clk) disable iff (!resetn)
      !state_reg.setup[OV_EN_BIT] |-> !ov_fault && gate_enable == !oc_fault)
      else $error("overvoltage acted on while disabled");

   chk_otw_report: assert property (@(posedge clk) disable iff (!resetn)
      $rose(state_reg.status[ST_OTW]) |-> $past(state_reg.setup[OVERTEMP_WARNING_REPORT_ENABLE_BIT]))
      else $error("warning reported while reporting disabled");

   chk_oc_cause: assert property (@(posedge clk) disable iff (!resetn)
      $rose(oc_fault) |-> $past(oc_filt) && state_reg.status[ST_OC])
      else $error("overcurrent fault without filtered detection");

   chk_oc_latch: assert property (@(posedge clk) disable iff (!resetn)
      oc_fault && oc_mode == OC_MODE_LATCH && !clr_bits[ST_OC] |=> oc_fault)
      else $error("latched overcurrent fault released by itself");

   chk_retry_early: assert property (@(posedge clk) disable iff (!resetn)
      oc_fault && (state_reg.retry_cnt != RETRY_CYCLES - 1'b1) && !wr_en
      |=> oc_fault)
      else $error("overcurrent retry released early");

   chk_retry_release: assert property (@(posedge clk) disable iff (!resetn)
      oc_fault && oc_mode == OC_MODE_RETRY && !oc_event
      && (state_reg.retry_cnt == RETRY_CYCLES - 1'b1) |=> !oc_fault ##1 oc_fault == $past(oc_filt))
      else $error("overcurrent retry not released at count");

   chk_static_gain: assert property (@(posedge clk) disable iff (!resetn)
      !state_reg.auto_gain ##1 !$past(state_reg.auto_gain)
      |-> sense_gain == $past(state_reg.setup[GAIN_LSB +: 2]))
      else $error("static gain not applied");

   chk_reserved_zero: assert property (@(posedge clk) disable iff (!resetn)
      rd_en && addr == SETUP_OFFSET |=> (rdata & ~SETUP_WMASK) == 32'h0000_0000)
      else $error("reserved bits read non-zero");

   chk_irq_level: assert property (@(posedge clk) disable iff (!resetn)
      irq == |(state_reg.status & state_reg.mask))
      else $error("interrupt does not follow masked status");
endmodule // gdps_top

// ### tb/tb_top.sv
// self-checking bench for the gate-drive protection setup block
`timescale 1ns/1ps
module tb_top
   import gdps_pkg::*;
;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic wr_en = 1'b0;
   logic rd_en = 1'b0;
   logic oc_pin = 1'b0;
   logic ov_pin = 1'b0;
   logic otw_pin = 1'b0;
   logic [1:0] auto_gain = 2'h0;
   logic [31:0] rdata;
   logic [1:0] slew_code, sense_gain;
   logic slew_valid, ov_threshold_sel, ov_fault, otw_report;
   logic oc_trip_level, oc_fault, gate_enable, irq;
   int failures = 0;
   int compares = 0;
   int cycles = 0;
   // deglitch lengths at 40 MHz: 0.2, 0.6, 1.2, 1.6 us
   int filt[4] = '{8, 24, 48, 64};

   always #12.5 clk = ~clk;

   // short retry count keeps the run brief; the retry checks hard-code waits that assume its 50 cycles
   gdps_top #(.RETRY_CYCLES(25'd50)) u_gdps_top (.clk(clk), .resetn(resetn), .addr(addr),
      .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .oc_detect_pin(oc_pin),
      .ov_detect_pin(ov_pin), .otw_detect_pin(otw_pin), .auto_gain_code(auto_gain),
      .slew_code(slew_code), .slew_valid(slew_valid), .ov_threshold_sel(ov_threshold_sel),
      .ov_fault(ov_fault), .otw_report(otw_report), .oc_trip_level(oc_trip_level),
      .oc_fault(oc_fault), .gate_enable(gate_enable), .sense_gain(sense_gain), .irq(irq));

   task automatic report_and_stop();
      if (failures == 0 && compares > 0)
      begin
         $display("NO MISMATCHES");
      end
      else
      begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         failures++;
         $display("unexpected %s: expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1;
      chk(name, rdata, exp);
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // hang guard, well above the roughly 1100 cycles the tests need
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         failures++;
         report_and_stop();
      end
   end

   initial
   begin
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      rd(SETUP_OFFSET, 32'h0000_0000, "setup reset");
      rd(AUX_OFFSET, 32'h0000_0400, "aux reset");
      chk("gate_enable", 32'(gate_enable), 32'h1);
      chk("irq", 32'(irq), 32'h0);
      // all ones: only the writable fields survive
      wr(SETUP_OFFSET, 32'hFFFF_FFFF);
      rd(SETUP_OFFSET, 32'h8C0D_3703, "setup mask");
      // response code 3 in that write is invalid and flags status bit 3
      rd(STATUS_OFFSET, 32'h0000_0008, "status invalid");
      wr(8'h40, 32'h1234_5678);
      rd(8'h40, 32'h0000_0000, "unmapped");
      rd(SETUP_OFFSET, 32'h8C0D_3703, "setup kept");
      wr(STATUS_OFFSET, 32'h0000_000F);
      wr(MASK_OFFSET, 32'h0000_0001);
      rd(MASK_OFFSET, 32'h0000_0001, "mask");
      for (int k = 0; k < 4; k++)
      begin
         wr(SETUP_OFFSET, 32'(k) << 26);
         cyc(1);
         chk("slew_code", 32'(slew_code), 32'(k));
         chk("slew_valid", 32'(slew_valid), 32'(k >= 2));
      end
      // ov and otw pins active while their enables are still clear
      ov_pin <= 1'b1;
      otw_pin <= 1'b1;
      wr(SETUP_OFFSET, 32'h0008_0400);
      cyc(6);
      chk("ov_sel", 32'(ov_threshold_sel), 32'h1);
      chk("oc_level", 32'(oc_trip_level), 32'h1);
      chk("ov_off", 32'(ov_fault), 32'h0);
      chk("otw_off", 32'(otw_report), 32'h0);
      chk("gate_on", 32'(gate_enable), 32'h1);
      wr(SETUP_OFFSET, 32'h0005_0000);
      cyc(2);
      chk("ov_sel0", 32'(ov_threshold_sel), 32'h0);
      chk("oc_level0", 32'(oc_trip_level), 32'h0);
      chk("ov_on", 32'(ov_fault), 32'h1);
      chk("otw_on", 32'(otw_report), 32'h1);
      chk("gate_off", 32'(gate_enable), 32'h0);
      ov_pin <= 1'b0;
      otw_pin <= 1'b0;
      cyc(6);
      chk("ov_gone", 32'(ov_fault), 32'h0);
      // ov and otw rises once enabled, plus the invalid slew writes
      rd(STATUS_OFFSET, 32'h0000_000E, "status events");
      wr(STATUS_OFFSET, 32'h0000_000F);
      // latched mode, every filter code: short pulse ignored, long one trips
      for (int k = 0; k < 4; k++)
      begin
         wr(SETUP_OFFSET, 32'(k) << 12);
         @(posedge clk);
         oc_pin <= 1'b1;
         repeat (filt[k] / 2) @(posedge clk);
         oc_pin <= 1'b0;
         cyc(filt[k] + 8);
         chk("oc_glitch", 32'(oc_fault), 32'h0);
         @(posedge clk);
         oc_pin <= 1'b1;
         cyc(filt[k] - 2);
         chk("oc_early", 32'(oc_fault), 32'h0);
         cyc(8);
         chk("oc_trip", 32'(oc_fault), 32'h1);
         chk("irq_on", 32'(irq), 32'h1);
         chk("gate_oc", 32'(gate_enable), 32'h0);
         @(posedge clk);
         oc_pin <= 1'b0;
         cyc(filt[k] + 80);
         chk("oc_latched", 32'(oc_fault), 32'h1);
         wr(STATUS_OFFSET, 32'h0000_0001);
         cyc(2);
         chk("oc_cleared", 32'(oc_fault), 32'h0);
         chk("irq_off", 32'(irq), 32'h0);
      end
      // automatic retry: fault stands for the retry count, then clears alone
      wr(SETUP_OFFSET, 32'h0000_0100);
      @(posedge clk);
      oc_pin <= 1'b1;
      cyc(12);
      chk("retry_trip", 32'(oc_fault), 32'h1);
      @(posedge clk);
      oc_pin <= 1'b0;
      cyc(29);
      chk("retry_hold", 32'(oc_fault), 32'h1);
      cyc(25);
      chk("retry_clear", 32'(oc_fault), 32'h0);
      wr(STATUS_OFFSET, 32'h0000_000F);
      for (int k = 0; k < 4; k++)
      begin
         wr(SETUP_OFFSET, 32'(k));
         cyc(2);
         chk("gain", 32'(sense_gain), 32'(k));
      end
      auto_gain <= 2'h1;
      wr(AUX_OFFSET, 32'h0000_0001);
      cyc(2);
      chk("gain_auto", 32'(sense_gain), 32'h1);
      wr(AUX_OFFSET, 32'h0000_0000);
      cyc(2);
      chk("gain_static", 32'(sense_gain), 32'h3);
      report_and_stop();
   end
endmodule // tb_top
